// *** design/slwd_pkg.sv ***
// Purpose: Shared constants and types of the low-power and watchdog controller.
// Assumes: A 200 MHz system clock; every cycle count derives from CLK_MHZ.
// Notes: The command opcodes are framed as one opcode byte and one data byte.
package slwd_pkg;
  // Time figures in their own units, and the clock rate they convert with.
  localparam longint CLK_MHZ = 200;
  localparam longint CYC_PER_MS = CLK_MHZ * 1000;
  localparam longint NREQ_LONG_MS = 256;
  localparam longint NREQ_SHORT_MS = 64;
  localparam longint RST_MS = 1;
  localparam longint WD_MS = 128;
  localparam longint FLASH_MS = 32000;
  localparam longint OC_MAX_MS = 32;
  localparam longint LPT_MS = 1024;
  localparam int INT_PULSE_US = 10;
  localparam int INT_PULSE_CYC = int'(CLK_MHZ) * INT_PULSE_US;

  // Counter width; the flash period needs 33 bits at this clock.
  localparam int CW = 33;
  localparam logic [4:0] SPI_BITS = 5'h10;
  localparam logic [7:0] LFSR_SEED = 8'hA5;
  localparam logic [12:0] SYNC_RST = 13'h0002;
  localparam int WF_TMR = 7;
  localparam int WF_OC = 8;

  // Command opcodes and data values.
  localparam logic [7:0] OP_WD = 8'h5A;
  localparam logic [7:0] OP_LPWD = 8'h5B;
  localparam logic [7:0] OP_MODE = 8'h5C;
  localparam logic [7:0] OP_RND = 8'h1B;
  localparam logic [7:0] OP_SECREQ = 8'h2D;
  localparam logic [7:0] OP_SECACK = 8'h2E;
  localparam logic [7:0] OP_CFG = 8'h31;
  localparam logic [7:0] OP_CLR = 8'h3C;
  localparam logic [7:0] MD_NREQ = 8'h10;
  localparam logic [7:0] MD_LPOFF = 8'h20;
  localparam logic [7:0] MD_LPON = 8'h40;
  localparam logic [7:0] MD_DBGX = 8'h80;
  localparam logic [1:0] SEC_INIT = 2'h1;
  localparam logic [1:0] SEC_FLASH = 2'h2;
  localparam logic [1:0] SEC_RST = 2'h3;
  localparam logic [1:0] WT_WIN = 2'h0;
  localparam logic [1:0] WT_TMO = 2'h1;
  localparam logic [1:0] WT_ADV = 2'h2;
  localparam logic [1:0] SP_2 = 2'h1;
  localparam logic [1:0] SP_4 = 2'h2;

  typedef enum logic [6:0] {
    M_INIT = 7'h01, M_RST = 7'h02, M_NREQ = 7'h04, M_NORM = 7'h08,
    M_FLASH = 7'h10, M_LPOFF = 7'h20, M_LPON = 7'h40
  } slwd_mode_t;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] dat;
  } slwd_cmd_t;

  typedef struct packed {
    logic [1:0] oc_sel;
    logic lpwd_en;
    logic nreq_short;
    logic [1:0] split;
    logic [1:0] wtype;
  } slwd_cfg_t;

  localparam slwd_cfg_t CFG_RST = 8'h00;
endpackage

// *** design/slwd_ctrl.sv ***
// Purpose: Mode sequencer, wake-up logic and watchdog of a system basis chip.
// Assumes: SPI mode 0, 16-bit frames, pins sampled through two flip-flops.
// Notes: MISO returns {supply-loss flag, mode, random code} in every frame.
// Overview of operation
// - SPI request or fail-safe enters supply-off low power; supplies switch off.
// - Supply-off low power watches CAN, LIN, timer, wake pins, cyclic sense.
// - Wake-up goes through Reset into Normal Request; sources stay readable.
// - Supply-on low power keeps main supply, others off, pass drive disabled.
// - Normal Request mode write wakes from supply-on low power.
// - Load current above threshold longer than selected time declares wake-up.
// - Wake-up from supply-on low power gives a low interrupt pulse.
// - Optional low-power timeout watchdog refreshed by command or short overcurrent.
// - Secured request shows a fresh random code; next command returns it inverted.
// - Normal to INIT or Flash only through the secured procedure; Reset also on a watchdog failure.
// - Critical settings writable only in INIT after power-on or secured return.
// - Normal Request timeout is long by default; short only after supply-on wake.
// - Normal Request watchdog is a plain timeout, refresh anytime.
// - Watchdog type chosen in INIT, window default, then locked.
// - Window refresh before half period or missing refresh forces Reset.
// - Window checking in Normal and Flash; period back to default after supply loss.
// - Debug keeps the watchdog counting but never resets.
// - SPI debug exit restarts the period; pin exit forces Reset.
// - Flash runs a long timeout with an interrupt pulse at half period.
// - Advanced refresh writes the inverted random byte in 1, 2 or 4 commands.
// - Low power is refused while any wake flag is set.
// - Simple refresh word accepted anytime in timeout, only in the open window in window type; advanced type counts it as a bad refresh.
`timescale 1ns/100ps
module slwd_ctrl
  import slwd_pkg::*;
#(
  parameter longint NREQ_LONG_CYC = NREQ_LONG_MS * CYC_PER_MS,
  parameter longint NREQ_SHORT_CYC = NREQ_SHORT_MS * CYC_PER_MS,
  parameter longint RST_CYC = RST_MS * CYC_PER_MS,
  parameter longint WD_CYC = WD_MS * CYC_PER_MS,
  parameter longint FLASH_CYC = FLASH_MS * CYC_PER_MS,
  parameter longint OC_MAX_CYC = OC_MAX_MS * CYC_PER_MS,
  parameter longint LPT_CYC = LPT_MS * CYC_PER_MS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic [6:0] ext_wake,
  input wire logic sleep_current_threshold,
  input wire logic failsafe_lp,
  input wire logic debug_select_pin,
  output logic rst_n,
  output logic int_n,
  output logic vdd_en,
  output logic can_supply_en,
  output logic aux_regulator_en,
  output logic pnp_en,
  output logic [6:0] mode_state,
  output logic [8:0] wake_flags,
  output logic batfail_flag,
  output logic debug_active,
  output slwd_cfg_t cfg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [12:0] sy1, sy2;
  logic [6:0] ew;
  logic oc_s, fs_s, dbg_s, sck_s, cs_s, mosi_s;
  logic sck_d, cs_d, frm, oc_d;
  logic [4:0] bitcnt;
  logic [15:0] sh;
  logic [14:0] tx;
  slwd_cmd_t cmd;
  slwd_mode_t mode, next_mode;
  logic [7:0] lfsr, rnd, pmask;
  logic [1:0] pidx, plast_idx, sec_pend, st;
  logic [CW-1:0] cnt, lim, lp_cnt, oc_cnt, oc_lim, half;
  logic [10:0] int_cnt;
  logic is_ref, ref0, is_mode, lp_req, any_wake, adv, win, early, exp;
  logic part_ok, ref_done, ref_bad, ref_ok, sec_req, sec_go, new_rnd;
  logic dbg_exit_spi, dbg_fall, restart, lp_refresh, oc_long, oc_short;
  logic tmr_hit, int_start, flash_half, cfg_open, use_short, cfg_wr_ok;

  // Pins cross into the clock domain; only sy2 is ever read by logic.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sy1 <= SYNC_RST;
      sy2 <= SYNC_RST;
    end else begin
      sy1 <= {ext_wake, sleep_current_threshold, failsafe_lp, debug_select_pin, spi_sck, spi_cs_n, spi_mosi};
      sy2 <= sy1;
    end
  end
  assign {ew, oc_s, fs_s, dbg_s, sck_s, cs_s, mosi_s} = sy2;

  // Receive shift register; a frame counts only with exactly 16 clocks.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sck_d <= 1'b0;
      cs_d <= 1'b1;
      bitcnt <= 5'h00;
      sh <= 16'h0000;
      frm <= 1'b0;
      cmd <= 16'h0000;
    end else begin
      sck_d <= sck_s;
      cs_d <= cs_s;
      frm <= 1'b0;
      if (cs_s) begin
        bitcnt <= 5'h00;
      end else if (sck_s && !sck_d) begin
        sh <= {sh[14:0], mosi_s};
        if (bitcnt != 5'h1F) begin
          bitcnt <= bitcnt + 5'h01;
        end
      end
      if (cs_s && !cs_d && bitcnt == SPI_BITS) begin
        frm <= 1'b1;
        cmd <= slwd_cmd_t'(sh);
      end
    end
  end

  // Transmit side: the code shown is the one valid at chip select fall.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx <= 15'h0000;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= !cs_s;
      if (!cs_s && cs_d) begin
        spi_miso <= batfail_flag;
        tx <= {mode, rnd};
      end else if (!sck_s && sck_d && !cs_s) begin
        spi_miso <= tx[14];
        tx <= {tx[13:0], 1'b0};
      end
    end
  end

  // Free-running LFSR; the code is latched only when a new one is due.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lfsr <= LFSR_SEED;
      rnd <= LFSR_SEED;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      if (new_rnd) begin
        rnd <= lfsr;
      end
    end
  end

  // Bits of the inverted code expected in command pidx of a split refresh.
  function automatic logic [7:0] part_mask(input logic [1:0] sp, input logic [1:0] idx);
    logic [7:0] m;
    m = 8'hFF;
    if (sp == SP_2) begin
      m = idx[0] ? 8'h0F : 8'hF0;
    end else if (sp == SP_4) begin
      m = 8'hC0 >> {idx, 1'b0};
    end
    return m;
  endfunction

  // Command decode and refresh checking.
  assign is_ref = frm && cmd.op == OP_WD;
  assign ref0 = is_ref && cmd.dat == 8'h00;
  assign is_mode = frm && cmd.op == OP_MODE;
  assign lp_req = is_mode && (cmd.dat == MD_LPOFF || cmd.dat == MD_LPON);
  assign any_wake = |wake_flags;
  assign adv = cfg.wtype == WT_ADV;
  assign win = cfg.wtype == WT_WIN;
  assign half = CW'(WD_CYC / 2);
  assign early = cnt < half;
  assign pmask = part_mask(cfg.split, pidx);
  assign plast_idx = (cfg.split == SP_2) ? 2'h1 : (cfg.split == SP_4) ? 2'h3 : 2'h0;
  assign part_ok = cmd.dat == (~rnd & pmask);
  assign ref_done = is_ref && (adv ? part_ok && pidx == plast_idx : cmd.dat == 8'h00);
  // Only the completing command is held to the window.
  assign ref_bad = (is_ref && (adv ? !part_ok : cmd.dat != 8'h00)) || (ref_done && win && early);
  assign ref_ok = ref_done && !(win && early);
  assign sec_req = frm && cmd.op == OP_SECREQ && cmd.dat[1:0] != 2'h0 && mode == M_NORM;
  assign sec_go = frm && cmd.op == OP_SECACK && sec_pend != 2'h0 && cmd.dat == ~rnd;
  assign new_rnd = sec_req || (mode == M_NORM && ref_ok && adv);
  assign dbg_exit_spi = is_mode && cmd.dat == MD_DBGX && debug_active;
  assign dbg_fall = debug_active && !dbg_s && st == 2'h3;
  assign cfg_wr_ok = mode == M_INIT && cfg_open;

  // Period of the running count in each mode.
  always_comb begin
    case (mode)
      M_INIT: lim = CW'(NREQ_LONG_CYC);
      M_RST: lim = CW'(RST_CYC);
      M_NREQ: lim = use_short ? CW'(NREQ_SHORT_CYC) : CW'(NREQ_LONG_CYC);
      M_NORM: lim = CW'(WD_CYC);
      M_FLASH: lim = CW'(FLASH_CYC);
      M_LPON: lim = CW'(WD_CYC);
      default: lim = {CW{1'b1}};
    endcase
  end
  assign exp = cnt >= lim - {{(CW-1){1'b0}}, 1'b1};

  // Mode sequencing; a watchdog reset is blocked while debug is active.
  always_comb begin
    next_mode = mode;
    if (dbg_fall) begin
      next_mode = M_RST;
    end else begin
      case (mode)
        M_INIT, M_NREQ: begin
          if (ref0) begin
            next_mode = M_NORM;
          end else if (exp && !debug_active) begin
            next_mode = M_RST;
          end
        end
        M_RST: begin
          if (exp) begin
            next_mode = M_NREQ;
          end
        end
        M_NORM: begin
          if (sec_go) begin
            case (sec_pend)
              SEC_INIT: next_mode = M_INIT;
              SEC_FLASH: next_mode = M_FLASH;
              default: next_mode = M_RST;
            endcase
          end else if ((ref_bad || exp) && !debug_active) begin
            next_mode = M_RST;
          end else if (lp_req && !any_wake) begin
            next_mode = (cmd.dat == MD_LPOFF) ? M_LPOFF : M_LPON;
          end else if (fs_s && !any_wake) begin
            next_mode = M_LPOFF;
          end
        end
        M_FLASH: begin
          if (is_mode || ((ref_bad || exp) && !debug_active)) begin
            next_mode = M_RST;
          end
        end
        M_LPOFF: begin
          if (any_wake) begin
            next_mode = M_RST;
          end
        end
        M_LPON: begin
          if (any_wake || (is_mode && cmd.dat == MD_NREQ)) begin
            next_mode = M_NREQ;
          end else if (cfg.lpwd_en && exp && !debug_active) begin
            next_mode = M_RST;
          end
        end
        default: next_mode = M_RST;
      endcase
    end
  end

  // Mode register and supply controls, registered from the next mode.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode <= M_INIT;
      rst_n <= 1'b1;
      vdd_en <= 1'b1;
      can_supply_en <= 1'b0;
      aux_regulator_en <= 1'b0;
      pnp_en <= 1'b0;
    end else begin
      mode <= next_mode;
      rst_n <= next_mode != M_RST;
      vdd_en <= next_mode != M_LPOFF;
      can_supply_en <= next_mode == M_NORM || next_mode == M_FLASH;
      aux_regulator_en <= next_mode == M_NORM;
      pnp_en <= next_mode == M_NORM || next_mode == M_FLASH;
    end
  end
  assign mode_state = mode;

  // One count serves every mode; in debug it wraps instead of resetting.
  assign lp_refresh = mode == M_LPON && ((frm && cmd.op == OP_LPWD) || oc_short);
  assign restart = next_mode != mode || (mode == M_NORM && ref_ok) || (mode == M_FLASH && ref0)
                   || dbg_exit_spi || lp_refresh;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt <= '0;
    end else if (restart || exp) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Wake timer and load-current timer of the low-power modes.
  assign oc_lim = CW'(OC_MAX_CYC) >> (2'h3 - cfg.oc_sel);
  assign oc_long = mode == M_LPON && oc_s && oc_cnt == oc_lim - {{(CW-1){1'b0}}, 1'b1};
  assign oc_short = oc_d && !oc_s && oc_cnt < oc_lim - {{(CW-1){1'b0}}, 1'b1};
  assign tmr_hit = lp_cnt == CW'(LPT_CYC - 1);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lp_cnt <= '0;
      oc_cnt <= '0;
      oc_d <= 1'b0;
    end else begin
      oc_d <= oc_s;
      if ((mode == M_LPOFF || mode == M_LPON) && !tmr_hit) begin
        lp_cnt <= lp_cnt + {{(CW-1){1'b0}}, 1'b1};
      end else begin
        lp_cnt <= '0;
      end
      if (mode == M_LPON && oc_s && !oc_long) begin
        oc_cnt <= oc_cnt + {{(CW-1){1'b0}}, 1'b1};
      end else if (!oc_s) begin
        oc_cnt <= '0;
      end
    end
  end

  // Sticky wake flags; a set in the clearing cycle survives the clear.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_flags <= 9'h000;
      batfail_flag <= 1'b1;
    end else begin
      if (frm && cmd.op == OP_CLR) begin
        batfail_flag <= 1'b0;
      end
      if (mode == M_LPOFF || mode == M_LPON) begin
        wake_flags <= ((frm && cmd.op == OP_CLR) ? 9'h000 : wake_flags) | {oc_long, tmr_hit, ew};
      end else if (frm && cmd.op == OP_CLR) begin
        wake_flags <= 9'h000;
      end
    end
  end

  // Settings: open after power-on and after a secured return to INIT only.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg <= CFG_RST;
      cfg_open <= 1'b1;
    end else begin
      if (frm && cmd.op == OP_CFG && cfg_wr_ok) begin
        cfg <= slwd_cfg_t'(cmd.dat);
      end
      if (mode == M_NORM && next_mode == M_INIT) begin
        cfg_open <= 1'b1;
      end else if (mode == M_INIT && next_mode != M_INIT) begin
        cfg_open <= 1'b0;
      end
    end
  end

  // Secured request slot, split refresh index and timeout choice.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sec_pend <= 2'h0;
      pidx <= 2'h0;
      use_short <= 1'b0;
    end else begin
      if (sec_req) begin
        sec_pend <= cmd.dat[1:0];
      end else if (frm) begin
        sec_pend <= 2'h0;
      end
      if (next_mode != mode || ref_done || ref_bad) begin
        pidx <= 2'h0;
      end else if (mode == M_NORM && adv && is_ref && part_ok) begin
        pidx <= pidx + 2'h1;
      end
      if (mode == M_LPON && next_mode == M_NREQ) begin
        use_short <= cfg.nreq_short;
      end else if (next_mode == M_RST) begin
        use_short <= 1'b0;
      end
    end
  end

  // Debug strap is caught once the synchroniser has settled after reset.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= 2'h0;
      debug_active <= 1'b0;
    end else begin
      if (st != 2'h3) begin
        st <= st + 2'h1;
      end
      if (st == 2'h2) begin
        debug_active <= dbg_s;
      end else if (dbg_fall || dbg_exit_spi) begin
        debug_active <= 1'b0;
      end
    end
  end

  // Interrupt pulse, fixed length so the host cannot miss it.
  assign flash_half = mode == M_FLASH && cnt == CW'(FLASH_CYC / 2);
  assign int_start = (mode == M_LPON && next_mode == M_NREQ) || flash_half;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_cnt <= 11'h000;
      int_n <= 1'b1;
    end else if (int_start) begin
      int_cnt <= 11'(INT_PULSE_CYC);
      int_n <= 1'b0;
    end else if (int_cnt != 11'h000) begin
      int_cnt <= int_cnt - 11'h001;
      int_n <= int_cnt == 11'h001;
    end
  end

  sequence s_lpon_wake;
    mode == M_LPON ##1 mode == M_NREQ;
  endsequence
  sequence s_early_ref;
    mode == M_NORM && win && ref0 && early && !debug_active && !dbg_fall && !sec_go;
  endsequence

  a_lp_off_supply: assert property (mode == M_LPOFF |-> !vdd_en && !can_supply_en && !aux_regulator_en)
    else $error("supplies on in supply-off low power");
  a_lp_on_supply: assert property (mode == M_LPON |-> vdd_en && !can_supply_en && !pnp_en)
    else $error("wrong supplies in supply-on low power");
  a_spi_wake: assert property (mode == M_LPON && is_mode && cmd.dat == MD_NREQ && !dbg_fall
    |=> mode == M_NREQ)
    else $error("normal request write did not wake");
  a_wake_pulse: assert property (s_lpon_wake |-> !int_n [*8])
    else $error("no interrupt pulse on wake");
  a_sec_only: assert property (mode == M_NORM && (next_mode == M_INIT || next_mode == M_FLASH) |-> sec_go)
    else $error("critical transition without secured ack");
  a_nreq_long: assert property (mode == M_NREQ && !use_short |-> lim == CW'(NREQ_LONG_CYC))
    else $error("normal request timeout not long");
  a_cfg_lock: assert property ($changed(cfg) |-> $past(cfg_wr_ok))
    else $error("settings changed outside INIT");
  a_win_early: assert property (s_early_ref |=> mode == M_RST)
    else $error("early window refresh not punished");
  a_dbg_hold: assert property (debug_active && mode == M_NORM && !frm && !fs_s && !dbg_fall
    |=> mode == M_NORM)
    else $error("debug mode left normal");
  a_dbg_spi: assert property (dbg_exit_spi && mode == M_NORM |=> cnt == '0 && !debug_active)
    else $error("debug exit did not restart period");
  a_lp_refuse: assert property (mode == M_NORM && lp_req && any_wake
    |=> mode != M_LPOFF && mode != M_LPON)
    else $error("low power entered with wake flag set");
endmodule

// *** verification/slwd_spi_host.sv ***
// Purpose: Behavioural host microcontroller driving the SPI pins of the controller.
// Assumes: SPI mode 0, 160 ns serial clock period, 16-bit frames sent MSB first.
// Notes: The serial clock stands still between frames and MOSI flips once the chip is deselected.
`timescale 1ns/100ps
module slwd_spi_host (
  input wire logic spi_miso,
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi
);
  // Idle pins at time zero; the clock idles low as mode 0 requires.
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // One whole frame; with inv set the data byte returns the code seen on MISO inverted.
  task automatic xfer(input logic [15:0] w, input bit inv, output logic [15:0] r);
    int i;
    spi_cs_n = 1'b0;
    #80;
    for (i = 15; i >= 0; i--) begin
      #60;
      spi_mosi = (inv && i < 8) ? ~spi_miso : w[i];
      #20 spi_sck = 1'b1;
      r[i] = spi_miso;
      #80 spi_sck = 1'b0;
    end
    #80 spi_cs_n = 1'b1;
    // A released line must not keep its last value, or a stale bit could pass for data.
    spi_mosi = ~spi_mosi;
    #40;
  endtask
endmodule

// *** verification/testbench.sv ***
// Purpose: Self-checking bench for the low-power mode and watchdog controller.
// Assumes: Shortened timer parameters; one frame takes about 550 clock cycles.
// Notes: Window period is 2000 cycles so a refresh frame fits inside the open half.
`timescale 1ns/100ps
module testbench;
  import slwd_pkg::*;
  localparam longint NL = 4000;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic [6:0] ext_wake = 7'h00;
  logic failsafe_lp = 1'b0;
  logic sleep_current_threshold = 1'b0;
  logic debug_select_pin = 1'b0;
  logic rst_n, int_n, vdd_en, can_supply_en, aux_regulator_en, pnp_en, batfail_flag, debug_active;
  logic [6:0] mode_state;
  logic [8:0] wake_flags;
  slwd_cfg_t cfg;
  logic [15:0] rx;
  logic [7:0] rnd;
  logic [6:0] wbit;
  int errors = 0;
  int num_checks = 0;
  int cnt;

  // Clock at 200 MHz.
  initial forever #2.5 clk = ~clk;

  slwd_spi_host host (.spi_miso, .spi_sck, .spi_cs_n, .spi_mosi);

  // Debug strap and load current idle low from bench signals so every watchdog expiry really acts.
  // The wake timer keeps its long default, so only the external wake pins end supply-off low power here.
  slwd_ctrl #(.NREQ_LONG_CYC(NL), .NREQ_SHORT_CYC(2000), .RST_CYC(50), .WD_CYC(2000),
    .FLASH_CYC(8000), .OC_MAX_CYC(160)) uut (
    .clk, .sys_rst, .spi_sck, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe, .ext_wake,
    .sleep_current_threshold, .failsafe_lp, .debug_select_pin, .rst_n, .int_n,
    .vdd_en, .can_supply_en, .aux_regulator_en, .pnp_en, .mode_state, .wake_flags,
    .batfail_flag, .debug_active, .cfg);

  // Prints the counts and the verdict, then ends the run.
  task results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Sends one frame and lets the mode update land before anything is sampled.
  task send(input logic [7:0] op, input logic [7:0] dat);
    host.xfer({op, dat}, 1'b0, rx);
    repeat (6) @(posedge clk);
    #1;
  endtask

  // Bounded wait for a mode; cnt returns the cycles spent waiting.
  task wait_mode(input logic [6:0] m, input int max);
    cnt = 0;
    while (mode_state !== m && cnt < max) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    if (cnt >= max) begin
      check("wait mode", 8'(mode_state), 8'(m));
      results;
    end
  endtask

  // Main sequence; each block leaves the device in a known mode for the next.
  initial begin
    void'($urandom(32'hB8A1));
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check("mode", 8'(mode_state), 8'(M_INIT));
    check("pins", {1'b0, rst_n, vdd_en, can_supply_en, aux_regulator_en, pnp_en, int_n, batfail_flag}, 8'h63);
    check("cfg", cfg, {6'h00, WT_WIN});
    send(OP_CFG, 8'h00);
    send(OP_WD, 8'h00);
    check("mode", 8'(mode_state), 8'(M_NORM));
    send(OP_WD, 8'h00);
    check("early", {1'b0, mode_state}, {1'b0, M_RST});
    check("rst_n", 8'(rst_n), 8'h00);
    wait_mode(M_NREQ, 200);
    send(OP_WD, 8'h00);
    repeat (600 + $urandom % 300) @(posedge clk);
    send(OP_WD, 8'h00);
    check("mode", 8'(mode_state), 8'(M_NORM));
    send(OP_CFG, 8'hFF);
    check("cfg", cfg, 8'h00);
    wait_mode(M_RST, 2500);
    check("rst_n", 8'(rst_n), 8'h00);
    wait_mode(M_NREQ, 200);
    wait_mode(M_RST, 4200);
    check("nreq time", 8'(cnt >= NL - 8 && cnt <= NL + 8), 8'h01);
    wait_mode(M_NREQ, 200);
    send(OP_WD, 8'h00);
    send(OP_CLR, 8'h00);
    send(OP_MODE, MD_LPON);
    check("mode", 8'(mode_state), 8'(M_LPON));
    check("supplies", {4'h0, vdd_en, can_supply_en, aux_regulator_en, pnp_en}, 8'h08);
    send(OP_MODE, MD_NREQ);
    check("mode", 8'(mode_state), 8'(M_NREQ));
    check("int_n", 8'(int_n), 8'h00);
    send(OP_WD, 8'h00);
    @(posedge clk) failsafe_lp <= 1'b1;
    wait_mode(M_LPOFF, 50);
    check("supplies", {5'h00, vdd_en, can_supply_en, aux_regulator_en}, 8'h00);
    wbit = 7'h01 << ($urandom % 7);
    @(posedge clk) failsafe_lp <= 1'b0;
    ext_wake <= wbit;
    wait_mode(M_RST, 100);
    wait_mode(M_NREQ, 200);
    ext_wake <= 7'h00;
    check("wake flags", 8'(wake_flags[6:0]), 8'(wbit));
    send(OP_WD, 8'h00);
    send(OP_MODE, MD_LPOFF);
    check("refused", 8'(mode_state), 8'(M_NORM));
    send(OP_SECREQ, {6'h00, SEC_INIT});
    host.xfer({OP_SECACK, 8'h00}, 1'b1, rx);
    repeat (6) @(posedge clk);
    #1;
    check("mode", 8'(mode_state), 8'(M_INIT));
    send(OP_CFG, {4'h0, SP_2, WT_ADV});
    check("cfg", cfg, {4'h0, SP_2, WT_ADV});
    send(OP_WD, 8'h00);
    send(OP_RND, 8'h00);
    rnd = rx[7:0];
    send(OP_WD, ~rnd & 8'hF0);
    send(OP_WD, ~rnd & 8'h0F);
    check("adv ok", 8'(mode_state), 8'(M_NORM));
    send(OP_RND, 8'h00);
    rnd = rx[7:0];
    send(OP_WD, rnd & 8'hF0);
    check("adv bad", 8'(mode_state), 8'(M_RST));
    results;
  end
endmodule
